/* src/qc_pkg.sv */
// shared constants and types for the quiet chopper amplitude scaling block
package qc_pkg;
    localparam int          CLK_HZ              = 125000000;
    localparam int          AMPL_W              = 8;
    localparam int          INTERVAL_W          = 20;
    localparam int          GRAD_SCALE          = 256;
    localparam int          GAIN_MAX            = 15;
    localparam logic [7:0]  AMPL_MAX            = 8'hff;
    localparam logic [7:0]  AMPL_RESET          = 8'h00;
    localparam logic [19:0] INTERVAL_MAX        = 20'hfffff;
    // standstill current control time in chopper periods
    localparam int          STANDSTILL_PERIODS  = 128;
    localparam logic [7:0]  STANDSTILL_COUNT    = 8'h80;
    // open-load window: full steps without reaching target
    localparam logic [2:0]  OL_FULLSTEPS        = 3'h4;
    // chopper period in clocks per frequency select: 1024/2, 683/2, 512/2, 410/2
    localparam logic [9:0]  PERIOD_SEL0         = 10'h200;
    localparam logic [9:0]  PERIOD_SEL1         = 10'h156;
    localparam logic [9:0]  PERIOD_SEL2         = 10'h100;
    localparam logic [9:0]  PERIOD_SEL3         = 10'h0cd;
    // fixed-point scaling of the velocity term: 256*clocks_per_microstep
    localparam logic [35:0] VEL_NUM_SCALE       = 36'h000000100;

    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_QUIET,
        MODE_CYCLE
    } chop_mode_t;

    function automatic logic [9:0] chopper_period(input logic [1:0] sel);
        case (sel)
            2'h0:    chopper_period = PERIOD_SEL0;
            2'h1:    chopper_period = PERIOD_SEL1;
            2'h2:    chopper_period = PERIOD_SEL2;
            default: chopper_period = PERIOD_SEL3;
        endcase
    endfunction : chopper_period
endpackage : qc_pkg

/* src/qc_if.sv */
// interface carrying amplitude request and result between submodules
`timescale 1ns/100ps
interface qc_if;
    import qc_pkg::*;
    logic [19:0] interval;
    logic [7:0]  offset;
    logic [7:0]  gradient;
    logic [7:0]  amplitude;
    logic        valid;
    modport requester (output interval, output offset, output gradient,
                       input amplitude, input valid);
    modport calculator (input interval, input offset, input gradient,
                        output amplitude, output valid);
endinterface : qc_if

/* src/qc_velocity_scale.sv */
// velocity-based amplitude: offset plus gradient*256/interval, saturated
`timescale 1ns/100ps
module qc_velocity_scale
    import qc_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // request and result
    qc_if.calculator  req
);
    typedef struct packed {
        logic [7:0] amplitude;
        logic       valid;
    } vel_state_t;

    vel_state_t state;
    vel_state_t next_state;
    logic [15:0] grad_term;
    logic [15:0] sum;

    // 256 microsteps per interval scale: fstep/fclk equals 1/interval
    always_comb begin
        grad_term = 16'h0000;
        if (req.interval != 20'h00000) begin
            grad_term = 16'((VEL_NUM_SCALE * 36'(req.gradient)) / 36'(req.interval)); // [R1] [R2]
        end else begin
            grad_term = 16'(AMPL_MAX);
        end
        sum = 16'(req.offset) + grad_term; // [R2]
        next_state = state;
        next_state.valid = 1'b1;
        if (sum > 16'(AMPL_MAX)) begin
            next_state.amplitude = AMPL_MAX; // [R19]
        end else begin
            next_state.amplitude = sum[7:0]; // [R3]
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state <= '{amplitude: AMPL_RESET, valid: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign req.amplitude = state.amplitude;
    assign req.valid     = state.valid;
endmodule : qc_velocity_scale

/* src/qc_regulator.sv */
// proportional current regulator for the quiet chopper amplitude
`timescale 1ns/100ps
module qc_regulator
    import qc_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // control
    input  wire logic       run,
    input  wire logic       period_tick,
    input  wire logic [3:0] gain,
    input  wire logic       load,
    input  wire logic [7:0] load_value,
    input  wire logic       below_target,
    input  wire logic       above_target,
    // result
    output logic      [7:0] amplitude,
    output logic            saturated
);
    typedef struct packed {
        logic [7:0] amplitude;
        logic       saturated;
    } reg_state_t;

    reg_state_t state;
    reg_state_t next_state;
    logic [8:0] up;

    always_comb begin
        next_state = state;
        up = 9'(state.amplitude) + 9'(gain);
        if (load) begin
            next_state.amplitude = load_value;
            next_state.saturated = 1'b0;
        end else if (run && period_tick) begin
            if (below_target) begin
                next_state.amplitude = up[8] ? AMPL_MAX : up[7:0];
                next_state.saturated = up[8] || (up[7:0] == AMPL_MAX);
            end else if (above_target) begin
                next_state.amplitude = (state.amplitude > 8'(gain)) ?
                                       state.amplitude - 8'(gain) : AMPL_RESET;
                next_state.saturated = 1'b0;
            end else begin
                next_state.saturated = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state <= '{amplitude: AMPL_RESET, saturated: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign amplitude = state.amplitude;
    assign saturated = state.saturated;
endmodule : qc_regulator

/* src/quiet_chopper_amplitude_scaling.sv */
// quiet chopper amplitude scaling, mode switch and open-load flags
`timescale 1ns/100ps
// Function
// R1: velocity mode derives amplitude from step interval, no current loop.
// R2: amplitude equals offset plus gradient times 256 over step interval.
// R3: amplitude is 8 bits; coil voltage is supply times amplitude over 374.
// R4: velocity-based scaling applies when automatic regulation is off.
// R5: quiet chopper only below velocity threshold, else cycle chopper.
// R6: threshold zero keeps quiet mode always; the code still leaves it below the cool-current or high-velocity threshold.
// R7: regulation amplitude held in cycle mode and reused on return.
// R8: with regulation on, offset caps re-entry amplitude.
// R9: host sets offset 255 or half to three quarters of last amplitude.
// R10: on first enable with regulation, 128 chopper periods standstill control.
// R11: host keeps threshold and supply steady while in cycle mode.
// R12: host clears error flags and restarts from zero velocity.
// R13: open-load flag when target not reached within last few full steps.
// R14: interrupted coil keeps its open-load flag asserted in quiet mode.
// R15: overcurrent in quiet mode sets driver error flag, sticky.
// R16: general enable bit selects whether the quiet chopper is used.
// R17: gradient is loop gain 1..15 with regulation, else 0..255.
// R18: quiet mode also off below cool-current or high-velocity threshold.
// R19: velocity amplitude saturates at 255 instead of wrapping.
module quiet_chopper_amplitude_scaling
    import qc_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // configuration
    input  wire logic        quiet_enable,
    input  wire logic        autoscale,
    input  wire logic [7:0]  amplitude_offset,
    input  wire logic [7:0]  amplitude_gradient,
    input  wire logic [19:0] quiet_mode_upper_threshold,
    input  wire logic [19:0] cool_current_threshold,
    input  wire logic [19:0] high_velocity_threshold,
    input  wire logic [1:0]  chopper_freq_select,
    // motion
    input  wire logic [19:0] step_interval,
    input  wire logic        standstill,
    input  wire logic        fullstep_tick,
    // current sense, per coil
    input  wire logic        coil_a_below_target,
    input  wire logic        coil_b_below_target,
    input  wire logic        coil_a_above_target,
    input  wire logic        coil_b_above_target,
    input  wire logic        overcurrent,
    input  wire logic        clear_errors,
    // status
    output logic      [7:0]  actual_amplitude,
    output logic             quiet_active,
    output logic             cycle_active,
    output logic             open_load_coil_a,
    output logic             open_load_coil_b,
    output logic             driver_error,
    output logic             standstill_done
);
    typedef struct packed {
        chop_mode_t mode;
        logic [7:0] amplitude;
        logic [7:0] held;
        logic       held_valid;
        logic [9:0] period_cnt;
        logic [7:0] still_cnt;
        logic       still_done;
        logic [2:0] miss_a;
        logic [2:0] miss_b;
        logic       reach_a;
        logic       reach_b;
        logic       ol_a;
        logic       ol_b;
        logic       err;
        logic       quiet;
        logic       cycle;
    } top_state_t;

    top_state_t state;
    top_state_t next_state;

    qc_if vel_bus ();

    logic       period_tick;
    logic       quiet_allowed;
    logic       reg_load;
    logic [7:0] reg_load_value;
    logic [7:0] reg_amplitude;
    logic [3:0] reg_gain;
    logic       reg_run;
    logic       below_any;
    logic       above_all;

    assign vel_bus.interval = step_interval;
    assign vel_bus.offset   = amplitude_offset;
    assign vel_bus.gradient = amplitude_gradient;

    qc_velocity_scale u_velocity (
        .mclk  (mclk),
        .reset (reset),
        .req   (vel_bus.calculator)
    );

    // gain clipped to 1..15 so the loop never stalls at zero
    always_comb begin
        if (amplitude_gradient == 8'h00) begin
            reg_gain = 4'h1; // [R17]
        end else if (amplitude_gradient > 8'(GAIN_MAX)) begin
            reg_gain = 4'(GAIN_MAX); // [R17]
        end else begin
            reg_gain = amplitude_gradient[3:0];
        end
    end

    assign period_tick = (state.period_cnt == 10'h000);
    assign below_any   = coil_a_below_target || coil_b_below_target;
    assign above_all   = coil_a_above_target && coil_b_above_target;
    assign reg_run     = autoscale && (state.mode == MODE_QUIET);

    // re-entry start: held value, capped by the offset setting
    always_comb begin
        reg_load_value = state.held_valid ? state.held : amplitude_offset; // [R7]
        if (reg_load_value > amplitude_offset) begin
            reg_load_value = amplitude_offset; // [R8]
        end
        reg_load = (state.mode != MODE_QUIET) && (next_state.mode == MODE_QUIET);
    end

    qc_regulator u_regulator (
        .mclk         (mclk),
        .reset        (reset),
        .run          (reg_run),
        .period_tick  (period_tick),
        .gain         (reg_gain),
        .load         (reg_load),
        .load_value   (reg_load_value),
        .below_target (below_any),
        .above_target (above_all),
        .amplitude    (reg_amplitude),
        .saturated    ()
    );

    // larger interval means lower velocity; threshold zero disables the switch
    always_comb begin
        quiet_allowed = quiet_enable; // [R16]
        if (quiet_mode_upper_threshold != 20'h00000) begin
            if (step_interval < quiet_mode_upper_threshold) begin
                quiet_allowed = 1'b0; // [R5]
            end
        end // [R6]
        if (step_interval < cool_current_threshold) begin
            quiet_allowed = 1'b0; // [R18]
        end
        if (step_interval < high_velocity_threshold) begin
            quiet_allowed = 1'b0; // [R18]
        end
    end

    always_comb begin
        next_state = state;
        if (period_tick) begin
            next_state.period_cnt = chopper_period(chopper_freq_select) - 10'h001;
        end else begin
            next_state.period_cnt = state.period_cnt - 10'h001;
        end

        case (state.mode)
            MODE_OFF: begin
                if (quiet_allowed) begin
                    next_state.mode = MODE_QUIET;
                end else if (quiet_enable) begin
                    next_state.mode = MODE_CYCLE;
                end
            end
            MODE_QUIET: begin
                if (!quiet_enable) begin
                    next_state.mode = MODE_OFF;
                end else if (!quiet_allowed) begin
                    next_state.mode = MODE_CYCLE;
                    next_state.held = reg_amplitude; // [R7]
                    next_state.held_valid = autoscale;
                end
            end
            MODE_CYCLE: begin
                if (!quiet_enable) begin
                    next_state.mode = MODE_OFF;
                end else if (quiet_allowed) begin
                    next_state.mode = MODE_QUIET;
                end
            end
            default: next_state.mode = MODE_OFF;
        endcase
        next_state.quiet = (next_state.mode == MODE_QUIET); // [R5]
        next_state.cycle = (next_state.mode == MODE_CYCLE); // [R5]

        // standstill current control after first enable with regulation
        if (!quiet_enable || !autoscale) begin
            next_state.still_cnt = 8'h00;
            next_state.still_done = 1'b0;
            next_state.held_valid = 1'b0;
        end else if (state.mode == MODE_QUIET && standstill && !state.still_done
                     && period_tick) begin
            next_state.still_cnt = state.still_cnt + 8'h01; // [R10]
            if (state.still_cnt == STANDSTILL_COUNT - 8'h01) begin
                next_state.still_done = 1'b1; // [R10]
            end
        end

        if (state.mode == MODE_QUIET && !autoscale) begin
            next_state.amplitude = vel_bus.amplitude; // [R1] [R4]
        end else if (state.mode == MODE_QUIET) begin
            next_state.amplitude = reg_amplitude;
        end

        // open-load detection over a window of full steps
        if (state.mode == MODE_QUIET && autoscale) begin
            if (!coil_a_below_target) begin
                next_state.reach_a = 1'b1;
            end
            if (!coil_b_below_target) begin
                next_state.reach_b = 1'b1;
            end
            if (fullstep_tick) begin
                next_state.miss_a = state.reach_a ? 3'h0 :
                    ((state.miss_a == OL_FULLSTEPS) ? state.miss_a : state.miss_a + 3'h1);
                next_state.miss_b = state.reach_b ? 3'h0 :
                    ((state.miss_b == OL_FULLSTEPS) ? state.miss_b : state.miss_b + 3'h1);
                next_state.reach_a = 1'b0;
                next_state.reach_b = 1'b0;
            end
            next_state.ol_a = (next_state.miss_a == OL_FULLSTEPS); // [R13] [R14]
            next_state.ol_b = (next_state.miss_b == OL_FULLSTEPS); // [R13] [R14]
        end else begin
            next_state.miss_a = 3'h0;
            next_state.miss_b = 3'h0;
            next_state.reach_a = 1'b0;
            next_state.reach_b = 1'b0;
            next_state.ol_a = 1'b0;
            next_state.ol_b = 1'b0;
        end

        // set wins over clear so a coincident fault is kept
        if (overcurrent && state.mode == MODE_QUIET) begin
            next_state.err = 1'b1; // [R15]
        end else if (clear_errors) begin
            next_state.err = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state <= '{mode: MODE_OFF, amplitude: AMPL_RESET, held: AMPL_RESET,
                       held_valid: 1'b0, period_cnt: 10'h000, still_cnt: 8'h00,
                       still_done: 1'b0, miss_a: 3'h0, miss_b: 3'h0,
                       reach_a: 1'b0, reach_b: 1'b0, ol_a: 1'b0, ol_b: 1'b0,
                       err: 1'b0, quiet: 1'b0, cycle: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign actual_amplitude = state.amplitude; // [R3]
    assign quiet_active     = state.quiet;
    assign cycle_active     = state.cycle;
    assign open_load_coil_a = state.ol_a;
    assign open_load_coil_b = state.ol_b;
    assign driver_error     = state.err;
    assign standstill_done  = state.still_done;
endmodule : quiet_chopper_amplitude_scaling

/* sim/qc_properties.sv */
// port-level assertions for the amplitude scaling block
`timescale 1ns/100ps
module qc_properties
    import qc_pkg::*;
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        reset,
    // configuration and motion
    input wire logic        quiet_enable,
    input wire logic        autoscale,
    input wire logic [7:0]  amplitude_offset,
    input wire logic [7:0]  amplitude_gradient,
    input wire logic [19:0] quiet_mode_upper_threshold,
    input wire logic [19:0] cool_current_threshold,
    input wire logic [19:0] high_velocity_threshold,
    input wire logic [19:0] step_interval,
    input wire logic        overcurrent,
    input wire logic        clear_errors,
    // status
    input wire logic [7:0]  actual_amplitude,
    input wire logic        quiet_active,
    input wire logic        cycle_active,
    input wire logic        driver_error
);
    logic [15:0] vel_term;
    logic [16:0] vel_sum;
    logic [7:0]  vel_exp;
    logic        allowed;

    // zero interval stands for infinite velocity, so it saturates
    always_comb begin
        vel_term = (step_interval == 20'h0) ? 16'hffff
                 : 16'(({amplitude_gradient, 8'h00}) / step_interval);
        vel_sum  = {9'h000, amplitude_offset} + {1'b0, vel_term};
        vel_exp  = (vel_sum > 17'h000ff) ? 8'hff : vel_sum[7:0];
        allowed  = (quiet_mode_upper_threshold == 20'h0
                    || step_interval >= quiet_mode_upper_threshold)
                   && step_interval >= cool_current_threshold
                   && step_interval >= high_velocity_threshold;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence s_vel_steady;
        quiet_active && !autoscale
        && $stable({amplitude_offset, amplitude_gradient, step_interval});
    endsequence
    sequence s_idle2;
        !quiet_active ##1 !quiet_active;
    endsequence

    property p_vel_ampl;
        s_vel_steady [*3] |-> actual_amplitude == vel_exp;
    endproperty
    a_vel_ampl: assert property (p_vel_ampl)
        else $error("velocity amplitude differs from formula");
    property p_quiet;
        quiet_enable && allowed |=> quiet_active && !cycle_active;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("quiet mode not entered at low velocity");
    property p_cycle;
        quiet_enable && !allowed |=> cycle_active && !quiet_active;
    endproperty
    a_cycle: assert property (p_cycle)
        else $error("cycle mode not entered at high velocity");
    property p_off;
        !quiet_enable |=> !quiet_active;
    endproperty
    a_off: assert property (p_off)
        else $error("quiet mode active while disabled");
    property p_hold;
        s_idle2 |-> $stable(actual_amplitude);
    endproperty
    a_hold: assert property (p_hold)
        else $error("amplitude moved outside quiet mode");
    property p_err_set;
        quiet_active && overcurrent |=> driver_error;
    endproperty
    a_err_set: assert property (p_err_set)
        else $error("overcurrent in quiet mode not flagged");
    property p_err_keep;
        driver_error && !clear_errors |=> driver_error;
    endproperty
    a_err_keep: assert property (p_err_keep)
        else $error("driver error dropped without clear");
    property p_err_clear;
        clear_errors && !overcurrent |=> !driver_error;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("driver error survived clear");
endmodule : qc_properties

bind quiet_chopper_amplitude_scaling qc_properties i_props (
    .mclk, .reset, .quiet_enable, .autoscale, .amplitude_offset, .amplitude_gradient,
    .quiet_mode_upper_threshold, .cool_current_threshold, .high_velocity_threshold,
    .step_interval, .overcurrent, .clear_errors, .actual_amplitude, .quiet_active,
    .cycle_active, .driver_error
);

/* sim/qc_coil_model.sv */
// two-coil motor model: current sense levels, stall and full-step pulses
`timescale 1ns/100ps
module qc_coil_model #(
    parameter int STEP_CLOCKS = 64
) (
    // clock and reset
    input wire logic       mclk,
    input wire logic       reset,
    // drive and faults
    input wire logic [7:0] actual_amplitude,
    input wire logic [7:0] need,
    input wire logic       open_a,
    input wire logic       open_b,
    input wire logic       stall,
    // sense
    output logic           coil_a_below_target,
    output logic           coil_b_below_target,
    output logic           coil_a_above_target,
    output logic           coil_b_above_target,
    output logic           overcurrent,
    output logic           fullstep_tick
);
    int cnt;

    // a broken coil never carries the target current
    assign coil_a_below_target = open_a || actual_amplitude < need;
    assign coil_b_below_target = open_b || actual_amplitude < need;
    assign coil_a_above_target = !open_a && actual_amplitude > need;
    assign coil_b_above_target = !open_b && actual_amplitude > need;
    assign overcurrent         = stall;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt           <= 0;
            fullstep_tick <= 1'b0;
        end else begin
            cnt           <= (cnt == STEP_CLOCKS - 1) ? 0 : cnt + 1;
            fullstep_tick <= (cnt == STEP_CLOCKS - 1);
        end
    end
endmodule : qc_coil_model

/* sim/quiet_chopper_amplitude_scaling_tb_top.sv */
// self-checking bench for the amplitude scaling block
`timescale 1ns/100ps
module quiet_chopper_amplitude_scaling_tb_top
    import qc_pkg::*;
;
    logic        mclk, reset, quiet_enable, autoscale, standstill, clear_errors;
    logic        open_a, open_b, stall, fullstep_tick, overcurrent;
    logic        coil_a_below_target, coil_b_below_target;
    logic        coil_a_above_target, coil_b_above_target;
    logic        quiet_active, cycle_active, open_load_coil_a, open_load_coil_b;
    logic        driver_error, standstill_done;
    logic [7:0]  amplitude_offset, amplitude_gradient, need, actual_amplitude;
    logic [19:0] quiet_mode_upper_threshold, cool_current_threshold;
    logic [19:0] high_velocity_threshold, step_interval;
    logic [1:0]  chopper_freq_select;
    int          n_fail, checks_done;
    logic [35:0] vt [6] = '{{8'h0a, 8'h01, 20'h00100}, {8'h00, 8'hff, 20'h00001},
        {8'hc8, 8'h64, 20'h00100}, {8'h05, 8'h00, 20'h00007},
        {8'h10, 8'h03, 20'h00000}, {8'h14, 8'hff, 20'h00400}};
    logic [80:0] mt [6] = '{{20'h003e8, 20'h0, 20'h0, 20'h003e7, 1'b0},
        {20'h003e8, 20'h0, 20'h0, 20'h003e8, 1'b1}, {20'h0, 20'h0, 20'h0, 20'h00001, 1'b1},
        {20'h0, 20'h001f4, 20'h0, 20'h00190, 1'b0}, {20'h0, 20'h0, 20'h001f4, 20'h00190, 1'b0},
        {20'hfffff, 20'h0, 20'h0, 20'hfffff, 1'b1}};

    quiet_chopper_amplitude_scaling i_dut (
        .mclk, .reset, .quiet_enable, .autoscale, .amplitude_offset, .amplitude_gradient,
        .quiet_mode_upper_threshold, .cool_current_threshold, .high_velocity_threshold,
        .chopper_freq_select, .step_interval, .standstill, .fullstep_tick,
        .coil_a_below_target, .coil_b_below_target, .coil_a_above_target,
        .coil_b_above_target, .overcurrent, .clear_errors, .actual_amplitude,
        .quiet_active, .cycle_active, .open_load_coil_a, .open_load_coil_b,
        .driver_error, .standstill_done);
    qc_coil_model i_coil (
        .mclk, .reset, .actual_amplitude, .need, .open_a, .open_b, .stall,
        .coil_a_below_target, .coil_b_below_target, .coil_a_above_target,
        .coil_b_above_target, .overcurrent, .fullstep_tick);

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick

    // bounded wait for the mode flag, a hang ends the run
    task automatic wait_mode(input logic q);
        int i;
        for (i = 0; i < 10 && quiet_active !== q; i++)
            tick(1);
        if (quiet_active !== q) begin
            n_fail++;
            tally_and_finish();
        end
    endtask : wait_mode

    function automatic logic [7:0] vel(input logic [35:0] e);
        logic [19:0] v;
        v = (e[19:0] == 20'h0) ? 20'hfffff : (20'(e[27:20]) * 20'h100) / e[19:0] + 20'(e[35:28]);
        vel = (v > 20'h000ff) ? 8'hff : v[7:0];
    endfunction : vel

    function automatic logic [7:0] in_band(input logic [7:0] lo, input logic [7:0] hi);
        in_band = {7'h00, actual_amplitude >= lo && actual_amplitude <= hi};
    endfunction : in_band

    initial begin
        {quiet_enable, autoscale, standstill, clear_errors, open_a, open_b, stall} = '0;
        {amplitude_offset, amplitude_gradient} = 16'h0000;
        {quiet_mode_upper_threshold, cool_current_threshold} = 40'h0;
        high_velocity_threshold = 20'h0;
        step_interval = 20'h00100;
        chopper_freq_select = 2'h3;
        need = 8'h64;
        n_fail = 0;
        checks_done = 0;
        reset = 1'b1;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        reset = 1'b0;
        quiet_enable = 1'b1;
        foreach (vt[i]) begin
            {amplitude_offset, amplitude_gradient, step_interval} = vt[i];
            tick(4);
            check("velocity amplitude", vel(vt[i]), actual_amplitude);
        end
        foreach (mt[i]) begin
            {quiet_mode_upper_threshold, cool_current_threshold, high_velocity_threshold,
             step_interval} = mt[i][80:1];
            tick(2);
            check("quiet mode", {7'h00, mt[i][0]}, {7'h00, quiet_active});
            check("cycle mode", {7'h00, !mt[i][0]}, {7'h00, cycle_active});
        end
        quiet_enable = 1'b0;
        tick(2);
        check("quiet while disabled", 8'h00, {7'h00, quiet_active});
        // regulated start from standstill, then out to cycle mode and back
        {cool_current_threshold, high_velocity_threshold} = 40'h0;
        quiet_mode_upper_threshold = 20'h00080;
        step_interval = 20'h00100;
        {autoscale, standstill, amplitude_offset, amplitude_gradient} = {2'b11, 16'h4004};
        tick(1);
        quiet_enable = 1'b1;
        tick(205 * 120);
        check("standstill done early", 8'h00, {7'h00, standstill_done});
        tick(205 * 12);
        check("standstill done", 8'h01, {7'h00, standstill_done});
        check("regulated amplitude", 8'h01, in_band(8'h60, 8'h68));
        standstill = 1'b0;
        step_interval = 20'h00040;
        wait_mode(1'b0);
        tick(500);
        check("held amplitude", 8'h01, in_band(8'h60, 8'h68));
        amplitude_offset = 8'hff;
        step_interval = 20'h00100;
        wait_mode(1'b1);
        tick(2);
        check("re-entry amplitude", 8'h01, in_band(8'h60, 8'h68));
        step_interval = 20'h00040;
        wait_mode(1'b0);
        amplitude_offset = 8'h32;
        step_interval = 20'h00100;
        wait_mode(1'b1);
        tick(3);
        check("capped re-entry", 8'h01, in_band(8'h00, 8'h36));
        open_a = 1'b1;
        tick(205 * 16);
        check("open load a", 8'h01, {7'h00, open_load_coil_a});
        check("open load b", 8'h00, {7'h00, open_load_coil_b});
        tick(64 * 4);
        check("open load a kept", 8'h01, {7'h00, open_load_coil_a});
        open_a = 1'b0;
        stall = 1'b1;
        tick(4);
        check("driver error", 8'h01, {7'h00, driver_error});
        stall = 1'b0;
        tick(4);
        check("driver error kept", 8'h01, {7'h00, driver_error});
        clear_errors = 1'b1;
        tick(2);
        clear_errors = 1'b0;
        check("driver error cleared", 8'h00, {7'h00, driver_error});
        tally_and_finish();
    end
endmodule : quiet_chopper_amplitude_scaling_tb_top
